// File: tb/host_irq_enable_mask_tb.sv
// self-checking bench for the host interrupt enable mask block
`timescale 1ns/1ps
module host_irq_enable_mask_tb;
  // short wake bound keeps the run brief
  localparam int WK = 16;
  // clock and reset
  logic clk_sys;
  logic nrst;
  // command port, event status, global enable and power inputs
  host_irq_pkg::cmd_t cmd;
  host_irq_pkg::rsp_t rsp;
  logic [6:0] host_event_status;
  logic [15:0] host_hw_config_register;
  logic suspend_req;
  logic resume_req;
  logic downstream_all_suspended;
  logic clk_stable_pin;
  // results
  logic host_irq_pin;
  logic sof_enable;
  logic host_suspended_evt;
  logic clk_ready_evt;
  logic [15:0] host_interrupt_enable_mask;
  // model state
  int mismatches;
  int cmp_count;
  integer seed;
  int model_mask;
  int n;
  int exp_q[$];
  logic [15:0] rv;

  host_irq_enable_mask #(.WAKE_CYCLES(WK)) i_host_irq_enable_mask (
    .clk_sys(clk_sys), .nrst(nrst), .cmd(cmd), .rsp(rsp),
    .host_event_status(host_event_status),
    .host_hw_config_register(host_hw_config_register),
    .suspend_req(suspend_req), .resume_req(resume_req),
    .downstream_all_suspended(downstream_all_suspended),
    .clk_stable_pin(clk_stable_pin), .host_irq_pin(host_irq_pin),
    .sof_enable(sof_enable), .host_suspended_evt(host_suspended_evt),
    .clk_ready_evt(clk_ready_evt),
    .host_interrupt_enable_mask(host_interrupt_enable_mask)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  // 5 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one-cycle strobe; outputs are looked at just after the taking edge
  task automatic cmd_go(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    cmd <= '{valid: 1'b1, code: c, data: d};
    @(posedge clk_sys);
    cmd <= '0;
    #1;
  endtask

  task automatic wr(input logic [15:0] d);
    cmd_go(host_irq_pkg::CMD_MASK_WRITE, d);
    model_mask = int'(d & 16'h0077);
    chk(host_interrupt_enable_mask === 16'(model_mask), "mask after write");
  endtask

  task automatic rd();
    exp_q.push_back(model_mask);
    cmd_go(host_irq_pkg::CMD_MASK_READ, 16'h0000);
    chk(rsp.valid === 1'b1 && rsp.data === 16'(exp_q.pop_front()), "mask read");
  endtask

  // write then read on back-to-back edges; valid stays up between the two
  task automatic wr_rd(input logic [15:0] d);
    @(posedge clk_sys);
    cmd <= '{valid: 1'b1, code: host_irq_pkg::CMD_MASK_WRITE, data: d};
    @(posedge clk_sys);
    cmd <= '{valid: 1'b1, code: host_irq_pkg::CMD_MASK_READ, data: 16'h0000};
    model_mask = int'(d & 16'h0077);
    @(posedge clk_sys);
    cmd <= '0;
    #1;
    chk(rsp.valid === 1'b1 && rsp.data === 16'(model_mask), "read after write");
  endtask

  // pin is the registered and-or of status, mask and global enable
  task automatic irq_step(input logic [6:0] st, input logic g);
    @(posedge clk_sys);
    rv = 16'($random(seed));
    host_event_status <= st;
    host_hw_config_register <= {rv[15:1], g};
    @(posedge clk_sys);
    #1;
    chk(host_irq_pin === ((|(st & 7'(model_mask))) & g), "irq gating");
  endtask

  // suspend, then wake with the oscillator flag held as given
  task automatic pwr_cycle(input logic stable);
    @(posedge clk_sys);
    suspend_req <= 1'b1;
    clk_stable_pin <= stable;
    @(posedge clk_sys);
    suspend_req <= 1'b0;
    #1;
    chk(sof_enable === 1'b1, "sof stays on while waiting");
    @(posedge clk_sys);
    #1;
    chk(host_suspended_evt === 1'b1 && sof_enable === 1'b0, "suspend entry");
    @(posedge clk_sys);
    resume_req <= 1'b1;
    @(posedge clk_sys);
    resume_req <= 1'b0;
    n = 0;
    while (clk_ready_evt !== 1'b1 && n < WK + 8) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (stable) chk(n >= 1 && n <= 6, "early wake");
    else chk(n >= WK - 2 && n <= WK + 2, "wake bound");
    @(posedge clk_sys);
    #1;
    chk(sof_enable === 1'b1 && clk_ready_evt === 1'b0, "run after wake");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = 25;
    mismatches = 0;
    cmp_count = 0;
    model_mask = 0;
    nrst = 1'b0;
    cmd = '0;
    host_event_status = 7'h00;
    host_hw_config_register = 16'h0000;
    suspend_req = 1'b0;
    resume_req = 1'b0;
    downstream_all_suspended = 1'b0;
    clk_stable_pin = 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(host_interrupt_enable_mask === host_irq_pkg::MASK_RESET, "reset mask");
    chk(host_irq_pin === 1'b0 && sof_enable === 1'b1, "reset outputs");
    rd();
    $display("test reset done");
    // every source on its own, plus reserved bit 3
    for (int b = 0; b < 7; b++) begin
      wr(16'h0001 << b);
      irq_step(7'h40, 1'b1);
      irq_step(7'h7f, 1'b1);
      irq_step(7'h7f & ~(7'h01 << b), 1'b1);
      irq_step(7'h7f, 1'b0);
    end
    wr(16'hff88);
    irq_step(7'h08, 1'b1);
    $display("test per-source gating done");
    // random masks and events; foreign code must not touch the mask
    repeat (24) begin
      rv = 16'($random(seed));
      wr(rv);
      rd();
      irq_step(7'($random(seed)), 1'($random(seed)));
      wr_rd(16'($random(seed)));
    end
    cmd_go(8'h27, 16'hffff);
    chk(rsp.valid === 1'b0 && host_interrupt_enable_mask === 16'(model_mask), "foreign");
    $display("test random traffic done");
    // reset in mid-run clears a live mask and a raised pin
    wr(16'h0077);
    irq_step(7'h7f, 1'b1);
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    model_mask = 0;
    @(posedge clk_sys);
    #1;
    chk(host_interrupt_enable_mask === 16'h0000 && host_irq_pin === 1'b0, "mid reset");
    rd();
    $display("test mid-run reset done");
    // downstream idle alone does not suspend a running host
    @(posedge clk_sys);
    downstream_all_suspended <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(host_suspended_evt === 1'b0 && sof_enable === 1'b1, "no suspend in run");
    pwr_cycle(1'b0);
    pwr_cycle(1'b1);
    $display("test power sequence done");
    conclude();
  end

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #(5 * 20000);
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
endmodule // host_irq_enable_mask_tb

// File: verilog/host_irq_enable_mask.sv
// host interrupt enable mask, suspend sequencer and wake-up clock-ready timer
`timescale 1ns/1ps
// Functional notes
// - Sixteen-bit read/write mask, all zero after reset; 15..7 and 3 reserved.
// - Bit 6 passes or blocks the clock-ready event onto the host interrupt.
// - Bit 5 passes or blocks the host-suspended event onto the host interrupt.
// - Suspend request waits for downstream suspend, then stops SOF and suspends.
// - Bit 4 passes the operational-register-update event onto the interrupt.
// - Bit 2 passes the end-of-transfer event onto the interrupt.
// - Bit 1 passes the asynchronous transfer list event onto the interrupt.
// - Bit 0 passes the start-of-frame event onto the interrupt.
// - Interrupt only when status bit, its mask bit and global enable are set.
// - Clock-ready flagged after wake-up once clock is stable, at most 1 ms.
module host_irq_enable_mask #(
  parameter int WAKE_CYCLES = host_irq_pkg::WAKE_MAX_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // command port from the shared processor bus front end
  input host_irq_pkg::cmd_t cmd,
  output host_irq_pkg::rsp_t rsp,
  // event status and global enable from the host side
  input wire logic [6:0] host_event_status,
  input wire logic [15:0] host_hw_config_register,
  // power control from the host control register logic
  input wire logic suspend_req,
  input wire logic resume_req,
  input wire logic downstream_all_suspended,
  input wire logic clk_stable_pin,
  // results
  output logic host_irq_pin,
  output logic sof_enable,
  output logic host_suspended_evt,
  output logic clk_ready_evt,
  output logic [15:0] host_interrupt_enable_mask
);

  // ************************************************************
  // command decode
  // ************************************************************
  logic mask_rd;
  logic mask_wr;
  logic [15:0] mask_r;
  logic [15:0] mask_nxt;
  host_irq_pkg::rsp_t rsp_r;

  // only the two mask codes are decoded, and only the read is answered; others are left to other blocks
  assign mask_rd = cmd.valid && (cmd.code == host_irq_pkg::CMD_MASK_READ);
  assign mask_wr = cmd.valid && (cmd.code == host_irq_pkg::CMD_MASK_WRITE);
  // reserved lanes are dropped at the write so they cannot hold a one
  assign mask_nxt = mask_wr ? (cmd.data & host_irq_pkg::MASK_WRITABLE) : mask_r;

  // mask register, cleared by reset so every source starts blocked
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mask_r <= host_irq_pkg::MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // read answer, one cycle after the command
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= mask_rd;
      rsp_r.data <= mask_rd ? mask_r : rsp_r.data;
    end
  end

  assign rsp = rsp_r;
  assign host_interrupt_enable_mask = mask_r;

  // ************************************************************
  // interrupt gating
  // ************************************************************
  logic [6:0] gated;
  logic global_en;
  logic irq_nxt;
  logic irq_r;

  // one mask bit per status bit; bit 3 of the mask is always zero here
  assign gated = host_event_status & mask_r[host_irq_pkg::EVT_W-1:0];
  assign global_en = host_hw_config_register[host_irq_pkg::BIT_GLOBAL_EN];
  assign irq_nxt = (|gated) && global_en;

  // registered pin so no decode glitch reaches the outside
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign host_irq_pin = irq_r;

  // ************************************************************
  // clock-stable synchroniser
  // ************************************************************
  logic stable_s1_r;
  logic stable_s2_r;

  // the oscillator status comes from outside the clock domain
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stable_s1_r <= 1'b0;
      stable_s2_r <= 1'b0;
    end else begin
      stable_s1_r <= clk_stable_pin;
      stable_s2_r <= stable_s1_r;
    end
  end

  // ************************************************************
  // suspend and wake-up sequencer
  // ************************************************************
  host_irq_pkg::pwr_state_t state_r;
  host_irq_pkg::pwr_state_t state_nxt;
  logic [19:0] wake_cnt_r;
  logic [19:0] wake_cnt_nxt;
  logic wake_done;
  logic susp_evt_nxt;
  logic rdy_evt_nxt;
  logic susp_evt_r;
  logic rdy_evt_r;
  logic sof_en_r;

  // the bound ends the wait even if the stable flag never comes
  assign wake_done = stable_s2_r ||
    (wake_cnt_r >= host_irq_pkg::WAKE_CNT_W'(WAKE_CYCLES - 1));

  // next state
  always_comb begin
    state_nxt = state_r;
    susp_evt_nxt = 1'b0;
    rdy_evt_nxt = 1'b0;
    case (state_r)
      host_irq_pkg::PWR_RUN: begin
        if (suspend_req) begin
          state_nxt = host_irq_pkg::PWR_SUSP_WAIT;
        end
      end
      host_irq_pkg::PWR_SUSP_WAIT: begin
        if (downstream_all_suspended) begin
          state_nxt = host_irq_pkg::PWR_SUSPENDED;
          susp_evt_nxt = 1'b1;
        end
      end
      host_irq_pkg::PWR_SUSPENDED: begin
        if (resume_req) begin
          state_nxt = host_irq_pkg::PWR_WAKING;
        end
      end
      host_irq_pkg::PWR_WAKING: begin
        if (wake_done) begin
          state_nxt = host_irq_pkg::PWR_RUN;
          rdy_evt_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = host_irq_pkg::PWR_RUN;
      end
    endcase
  end

  // wake counter runs only while waking; it clears on the exit cycle so it never
  // reaches the bound itself and the next wake-up starts from zero
  assign wake_cnt_nxt = ((state_r == host_irq_pkg::PWR_WAKING) && !wake_done) ?
    (wake_cnt_r + host_irq_pkg::WAKE_CNT_ONE) : host_irq_pkg::WAKE_CNT_ZERO;

  // state, counter and event pulses
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= host_irq_pkg::PWR_RUN;
      wake_cnt_r <= host_irq_pkg::WAKE_CNT_ZERO;
      susp_evt_r <= 1'b0;
      rdy_evt_r <= 1'b0;
      sof_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      susp_evt_r <= susp_evt_nxt;
      rdy_evt_r <= rdy_evt_nxt;
      sof_en_r <= (state_nxt == host_irq_pkg::PWR_RUN) ||
        (state_nxt == host_irq_pkg::PWR_SUSP_WAIT);
    end
  end

  assign sof_enable = sof_en_r;
  assign host_suspended_evt = susp_evt_r;
  assign clk_ready_evt = rdy_evt_r;

  // ************************************************************
  // assertions
  // ************************************************************
  AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mask_r & ~host_irq_pkg::MASK_WRITABLE) == 16'h0000)
    else $error("reserved mask bit holds a one");

  AST_RESET_CLEARS: assert property (@(posedge clk_sys)
    !nrst |=> (mask_r == host_irq_pkg::MASK_RESET) && !host_irq_pin)
    else $error("mask or pin not clear after reset");

  AST_WRITE_READBACK: assert property (@(posedge clk_sys) disable iff (!nrst)
    mask_wr ##1 (mask_rd && !mask_wr) |=> rsp.valid &&
      (rsp.data == ($past(cmd.data, 2) & host_irq_pkg::MASK_WRITABLE)))
    else $error("mask read does not return the written value");

  AST_CLK_READY_BLOCKED: assert property (@(posedge clk_sys) disable iff (!nrst)
    (host_event_status == 7'h40) && !mask_r[6] |=> !host_irq_pin)
    else $error("clock-ready event raised interrupt while masked");

  AST_SUSPENDED_PASSED: assert property (@(posedge clk_sys) disable iff (!nrst)
    host_event_status[5] && mask_r[5] && global_en |=> host_irq_pin)
    else $error("host-suspended event did not raise interrupt");

  AST_OPREG_PASSED: assert property (@(posedge clk_sys) disable iff (!nrst)
    host_event_status[4] && mask_r[4] && global_en |=> host_irq_pin)
    else $error("op register event did not raise interrupt");

  AST_DONE_PASSED: assert property (@(posedge clk_sys) disable iff (!nrst)
    host_event_status[2] && mask_r[2] && global_en |=> host_irq_pin)
    else $error("end-of-transfer event did not raise interrupt");

  AST_ASYNC_PASSED: assert property (@(posedge clk_sys) disable iff (!nrst)
    host_event_status[1] && mask_r[1] && global_en |=> host_irq_pin)
    else $error("async list event did not raise interrupt");

  AST_SOF_PASSED: assert property (@(posedge clk_sys) disable iff (!nrst)
    host_event_status[0] && mask_r[0] && global_en |=> host_irq_pin)
    else $error("start-of-frame event did not raise interrupt");

  AST_PIN_CAUSE: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(host_irq_pin) |-> $past(|(host_event_status & mask_r[6:0]) && global_en))
    else $error("interrupt pin rose without an enabled source");

  AST_SUSPEND_STOPS_SOF: assert property (@(posedge clk_sys) disable iff (!nrst)
    host_suspended_evt |-> !sof_enable ##1 !sof_enable)
    else $error("start-of-frame still enabled after suspend");

  AST_WAKE_BOUND: assert property (@(posedge clk_sys) disable iff (!nrst)
    wake_cnt_r < host_irq_pkg::WAKE_CNT_W'(WAKE_CYCLES))
    else $error("wake-up wait ran past its bound");

endmodule // host_irq_enable_mask

// File: verilog/host_irq_pkg.sv
// package: constants and carriers for the host interrupt enable mask block
package host_irq_pkg;

  // ************************************************************
  // register access
  // ************************************************************
  localparam logic [7:0] CMD_MASK_READ = 8'h25;
  localparam logic [7:0] CMD_MASK_WRITE = 8'ha5;
  localparam int REG_W = 16;
  localparam int EVT_W = 7;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  // bits 6,5,4,2,1,0 hold state; 15..7 and 3 are reserved
  localparam logic [15:0] MASK_WRITABLE = 16'h0077;

  // ************************************************************
  // bit positions of the event sources and the global enable
  // ************************************************************
  localparam int BIT_CLK_READY = 6;
  localparam int BIT_HOST_SUSPENDED = 5;
  localparam int BIT_OP_REG_UPDATE = 4;
  localparam int BIT_TRANSFER_DONE = 2;
  localparam int BIT_ASYNC_LIST = 1;
  localparam int BIT_SOF = 0;
  localparam int BIT_GLOBAL_EN = 0;

  // ************************************************************
  // wake-up timing
  // ************************************************************
  localparam int CLK_MHZ = 200;
  localparam int WAKE_MAX_US = 1000;
  localparam int WAKE_MAX_CYCLES = WAKE_MAX_US * CLK_MHZ;
  localparam int WAKE_CNT_W = 20;
  localparam logic [19:0] WAKE_CNT_ZERO = 20'h00000;
  localparam logic [19:0] WAKE_CNT_ONE = 20'h00001;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } rsp_t;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SUSP_WAIT,
    PWR_SUSPENDED,
    PWR_WAKING
  } pwr_state_t;

endpackage
